// >>> design/das_staging.sv
// Output staging of a dual pipelined converter with an APB register port.
// How it works
// [R1] Each channel outputs the word sampled four sample clocks earlier.
// [R2] Outputs update after the rising edge of that channel's clock; in align mode channel B updates after its falling edge instead.
// [R3] Format select high gives twos complement, low offset binary.
// [R4] A channel in standby leaves its result bus undriven.
// [R5] After standby a channel needs 15 sample clocks for good words.
// [R6] Both option selects low put both channels in standby.
// [R7] First low, second high puts only channel B in standby.
// [R8] First high, second low runs both channels without skew.
// [R9] Both high delays channel B output by half a clock cycle.
// [R10] Standby ignores the affected channel's sample clock.
// [R11] Shared clock with align puts B updates half a period after A.
// [R12] Shared clock without align updates both channels together.
// [R13] Clocks half a period apart with align give B data at A edge.
// [R14] Words come from five stage codes plus a three-bit flash.
// [R15] Channel B has its own sample clock input.
// [R16] Each channel drives its own eight-bit result bus.
// [R17] In align mode B output is retimed on B's falling clock edge.
module das_staging (
    // APB slave port.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [das_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap pins.
    input wire logic option_select_first,
    input wire logic option_select_second,
    input wire logic format_select,
    // Channel A converter core.
    input wire logic chan_a_sample_clock,
    input wire logic [das_pkg::RAW_W-1:0] chan_a_raw_code,
    // Channel B converter core.
    input wire logic chan_b_sample_clock,
    input wire logic [das_pkg::RAW_W-1:0] chan_b_raw_code,
    // Channel A result.
    output logic [das_pkg::WORD_W-1:0] chan_a_result_bus,
    output logic chan_a_result_oe_n,
    output logic chan_a_result_valid,
    input wire logic chan_a_result_ready,
    // Channel B result.
    output logic [das_pkg::WORD_W-1:0] chan_b_result_bus,
    output logic chan_b_result_oe_n,
    output logic chan_b_result_valid,
    input wire logic chan_b_result_ready
);
    import das_pkg::*;

    // ==========================================================
    // State record.
    typedef struct packed {
        logic [1:0] clk_meta, clk_sync, clk_last;
        logic [1:0][RAW_W-1:0] raw_meta, raw_sync;
        logic [2:0] strap_meta, strap_sync;
        logic [1:0][PIPE_DEPTH-1:0][WORD_W-1:0] pipe;
        logic [1:0][PIPE_DEPTH-1:0] pipe_valid;
        logic [1:0][PIPE_DEPTH-1:0] pipe_good;
        logic [1:0][RECOV_W-1:0] recov;
        logic [WORD_W-1:0] hold_word;
        logic hold_valid, discard;
        logic [1:0] overrun;
        logic [1:0][COUNT_W-1:0] count;
        logic [1:0] oe_n;
        logic [31:0] rdata;
        logic ready, slverr;
    } das_state_type;

    das_state_type st;
    das_state_type next_st;

    // ==========================================================
    // Combinational signals.
    das_mode_type mode;
    logic fmt_twos;
    logic [1:0] stby, rise, fall, clk_pin, word_valid, push_valid;
    logic [1:0] push_ready, buf_valid, pop_ready, recovering;
    logic [1:0][RAW_W-1:0] raw_pin;
    logic [1:0][WORD_W-1:0] word_data, push_data, buf_data;
    logic [31:0] status;

    // ==========================================================
    // Word assembly.
    // Adds the stage decisions with overlap, then saturates at full scale.
    function automatic logic [WORD_W-1:0] das_correct(
        input logic [RAW_W-1:0] raw
    );
        logic [WORD_W:0] acc;
        logic [1:0] code;
        acc = {6'h00, raw[FLASH_W-1:0]};
        for (int i = 0; i < STAGE_COUNT; i++) begin
            code = raw[RAW_W - 2 - 2 * i +: 2];
            if (code == 2'h3) begin
                code = 2'h2;
            end
            acc = acc + ({7'h00, code} << (STAGE_COUNT + 1 - i));
        end
        return acc[WORD_W] ? '1 : acc[WORD_W-1:0];
    endfunction

    // Offset binary passes through; twos complement flips the top bit.
    function automatic logic [WORD_W-1:0] das_format(
        input logic [WORD_W-1:0] word,
        input logic twos
    );
        return twos ? {~word[WORD_W-1], word[WORD_W-2:0]} : word;
    endfunction

    // ==========================================================
    // Pin grouping and decode.
    // Channel B keeps a clock input of its own.
    assign clk_pin = {chan_b_sample_clock, chan_a_sample_clock}; // see [R15]
    assign raw_pin = {chan_b_raw_code, chan_a_raw_code};
    assign pop_ready = {chan_b_result_ready, chan_a_result_ready};
    assign fmt_twos = st.strap_sync[2];

    // Strap decode; the first select is the upper bit of the pair.
    always_comb begin
        case ({st.strap_sync[0], st.strap_sync[1]})
            2'b00: mode = DAS_STANDBY_BOTH; // see [R6]
            2'b01: mode = DAS_STANDBY_B; // see [R7]
            2'b10: mode = DAS_NORMAL; // see [R8]
            default: mode = DAS_ALIGN; // see [R9]
        endcase
    end

    // Standby flags and clock edges seen through the synchronisers.
    assign stby[0] = (mode == DAS_STANDBY_BOTH);
    assign stby[1] = (mode == DAS_STANDBY_BOTH) || (mode == DAS_STANDBY_B);
    assign rise = st.clk_sync & ~st.clk_last;
    assign fall = ~st.clk_sync & st.clk_last;

    // Status word as software reads it.
    always_comb begin
        status = '0;
        for (int c = 0; c < 2; c++) begin
            recovering[c] = (st.recov[c] != '0);
        end
        status[ST_MODE_LSB +: 2] = mode;
        status[ST_STANDBY_LSB +: 2] = stby;
        status[ST_RECOVER_LSB +: 2] = recovering;
        status[ST_VALID_LSB +: 2] = buf_valid;
        status[ST_OVERRUN_LSB +: 2] = st.overrun;
    end

    // ==========================================================
    // Next state.
    always_comb begin
        next_st = st;
        word_valid = 2'b00;
        word_data = '0;
        push_valid = 2'b00;
        push_data = '0;

        // Pins from outside the clock domain pass two flip-flops.
        next_st.clk_meta = clk_pin;
        next_st.clk_sync = st.clk_meta;
        next_st.clk_last = st.clk_sync;
        next_st.raw_meta = raw_pin;
        next_st.raw_sync = st.raw_meta;
        next_st.strap_meta = {format_select, option_select_second,
                              option_select_first};
        next_st.strap_sync = st.strap_meta;

        // Per channel pipeline, advanced by that channel's own edge.
        for (int c = 0; c < 2; c++) begin
            next_st.oe_n[c] = stby[c]; // see [R4]
            if (stby[c]) begin
                // Clock ignored; pipeline emptied; recovery re-armed.
                next_st.pipe_valid[c] = '0; // see [R10]
                next_st.recov[c] = RECOVERY_CYCLES; // see [R5]
            end else if (rise[c]) begin
                next_st.pipe[c] = {st.pipe[c][PIPE_DEPTH-2:0],
                                   das_correct(st.raw_sync[c])}; // see [R14]
                next_st.pipe_valid[c] = {st.pipe_valid[c][PIPE_DEPTH-2:0],
                                         1'b1};
                next_st.pipe_good[c] = {st.pipe_good[c][PIPE_DEPTH-2:0],
                                        st.recov[c] == '0}; // see [R5]
                if (st.recov[c] != '0) begin
                    next_st.recov[c] = st.recov[c] - 1'b1;
                end
                // The oldest word leaves on the fourth edge after capture.
                if (st.pipe_valid[c][PIPE_DEPTH-1] &&
                    (st.pipe_good[c][PIPE_DEPTH-1] || !st.discard)) begin
                    word_valid[c] = 1'b1; // see [R1] [R2]
                    word_data[c] = das_format(st.pipe[c][PIPE_DEPTH-1],
                                              fmt_twos); // see [R3]
                end
            end
        end

        // Without align both channels hand on at their rising edge.
        push_valid = word_valid; // see [R12]
        push_data = word_data;
        next_st.hold_valid = 1'b0;
        if (mode == DAS_ALIGN) begin
            // Channel B words wait for the falling edge of its clock.
            push_valid[1] = fall[1] && st.hold_valid; // see [R17] [R11]
            push_data[1] = st.hold_word; // see [R13]
            next_st.hold_valid = st.hold_valid;
            if (word_valid[1]) begin
                next_st.hold_word = word_data[1];
                next_st.hold_valid = 1'b1;
            end else if (fall[1]) begin
                next_st.hold_valid = 1'b0;
            end
        end

        // APB setup cycle: decode and register the answer.
        next_st.ready = 1'b0;
        next_st.slverr = 1'b0;
        if (psel && !penable) begin
            next_st.ready = 1'b1;
            next_st.rdata = '0;
            if (paddr == CTRL_ADDR) begin
                next_st.rdata[CTRL_DISCARD_BIT] = st.discard;
            end else if (paddr == STATUS_ADDR) begin
                next_st.rdata = status;
            end else if (paddr == COUNT_ADDR) begin
                next_st.rdata = {st.count[1], st.count[0]};
            end else begin
                next_st.slverr = 1'b1;
            end
        end

        // APB access cycle: writes act at the completing edge.
        if (psel && penable && st.ready && pwrite && !st.slverr) begin
            if (paddr == CTRL_ADDR) begin
                next_st.discard = pwdata[CTRL_DISCARD_BIT];
            end else if (paddr == STATUS_ADDR) begin
                next_st.overrun = st.overrun &
                                  ~pwdata[ST_OVERRUN_LSB +: 2];
            end else if (paddr == COUNT_ADDR) begin
                next_st.count = '0;
            end
        end

        // Delivered words are counted; refused ones raise overrun.
        for (int c = 0; c < 2; c++) begin
            if (push_valid[c] && push_ready[c]) begin
                next_st.count[c] = next_st.count[c] + 1'b1;
            end else if (push_valid[c]) begin
                next_st.overrun[c] = 1'b1;
            end
        end
    end

    // ==========================================================
    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.oe_n <= 2'b11;
            st.recov <= {RECOVERY_CYCLES, RECOVERY_CYCLES};
            st.discard <= CTRL_DISCARD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Output buffers, one per channel.
    for (genvar c = 0; c < 2; c++) begin : g_chan
        das_skid_buffer #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
            .clk(pclk),
            .rst_n(presetn),
            .flush(stby[c]),
            .in_valid(push_valid[c]),
            .in_data(push_data[c]),
            .in_ready(push_ready[c]),
            .out_valid(buf_valid[c]),
            .out_data(buf_data[c]),
            .out_ready(pop_ready[c])
        );
    end

    // Each channel has its own result bus and enable.
    assign chan_a_result_bus = buf_data[0]; // see [R16]
    assign chan_b_result_bus = buf_data[1];
    assign chan_a_result_valid = buf_valid[0];
    assign chan_b_result_valid = buf_valid[1];
    assign chan_a_result_oe_n = st.oe_n[0];
    assign chan_b_result_oe_n = st.oe_n[1];
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;

    // ==========================================================
    // Assertions.
    default clocking das_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Both straps low float both buses from the next cycle on.
    both_standby_a: assert property ( // see [R6]
        mode == DAS_STANDBY_BOTH |=>
            chan_a_result_oe_n && chan_b_result_oe_n)
        else $error("both buses not floated in standby");
    // Standby of B alone keeps channel A driving.
    b_standby_a: assert property ( // see [R7]
        mode == DAS_STANDBY_B |=>
            chan_b_result_oe_n && !chan_a_result_oe_n)
        else $error("wrong bus floated in B standby");
    // Normal and align modes drive both buses.
    normal_drive_a: assert property ( // see [R8]
        (mode == DAS_NORMAL || mode == DAS_ALIGN) |=>
            !chan_a_result_oe_n && !chan_b_result_oe_n)
        else $error("bus floated outside standby");
    // A channel in standby offers no word.
    standby_quiet_a: assert property ( // see [R4]
        stby[0] |=> !chan_a_result_valid)
        else $error("channel A valid during standby");
    // The B pipeline stands still while its clock is ignored.
    clock_ignored_a: assert property ( // see [R10]
        stby[1] |=> $stable(st.pipe[1]) && st.pipe_valid[1] == '0)
        else $error("channel B pipeline moved in standby");
    // Leaving standby starts the full count; early samples are marked bad.
    recovery_arm_a: assert property ( // see [R5]
        ($fell(stby[0]) |-> st.recov[0] == RECOVERY_CYCLES) and
        (rise[0] && !stby[0] && st.recov[0] != '0 |=> !st.pipe_good[0][0]))
        else $error("recovery not armed on standby exit");
    // A good old word leaves at the rising edge that displaces it.
    latency_out_a: assert property ( // see [R1]
        rise[0] && !stby[0] && st.pipe_valid[0][PIPE_DEPTH-1] &&
        st.pipe_good[0][PIPE_DEPTH-1] |-> push_valid[0])
        else $error("channel A word not handed on");
    // Twos complement flips only the top bit of the stored word.
    format_msb_a: assert property ( // see [R3]
        push_valid[0] && fmt_twos |->
            push_data[0] == {~st.pipe[0][PIPE_DEPTH-1][WORD_W-1],
                             st.pipe[0][PIPE_DEPTH-1][WORD_W-2:0]})
        else $error("format select not applied");
    // Captured words equal the corrected stage decisions.
    correct_word_a: assert property ( // see [R14]
        rise[0] && !stby[0] |=>
            st.pipe[0][0] == das_correct($past(st.raw_sync[0])))
        else $error("corrected word mismatch");
    // In align mode channel B never hands on at a rising edge.
    align_defer_a: assert property ( // see [R17]
        mode == DAS_ALIGN && rise[1] |-> !push_valid[1])
        else $error("channel B pushed on rising edge in align");
    // In align mode the held word goes out at the falling edge.
    align_release_a: assert property ( // see [R9]
        mode == DAS_ALIGN && fall[1] && st.hold_valid |->
            push_valid[1] && push_data[1] == st.hold_word)
        else $error("held channel B word not released");
    // Without align, channel B hands on at its rising edge.
    same_edge_a: assert property ( // see [R12]
        mode == DAS_NORMAL && rise[1] && st.pipe_valid[1][PIPE_DEPTH-1]
        && !st.discard |-> push_valid[1])
        else $error("channel B word missed in normal mode");
    // Each setup cycle is answered in the next cycle.
    apb_answer_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("APB answer timing wrong");
    // Main scenarios.
    align_push_c: cover property (mode == DAS_ALIGN && push_valid[1]);
    recovery_done_c: cover property ($fell(recovering[0]));
    overrun_c: cover property ($rose(st.overrun[1]));
    apb_error_c: cover property (pready && pslverr);

endmodule // das_staging

// >>> inc/das_pkg.sv
// Shared constants and types of the dual converter output staging block.
package das_pkg;

    // ==========================================================
    // Word and pipeline sizes.
    localparam int WORD_W = 8;
    localparam int FLASH_W = 3;
    localparam int STAGE_COUNT = 5;
    localparam int RAW_W = 2 * STAGE_COUNT + FLASH_W;
    localparam int PIPE_DEPTH = 4;
    localparam int BUF_DEPTH = 2;
    localparam int COUNT_W = 16;
    localparam int ADDR_W = 12;

    // ==========================================================
    // Sample clocks of recovery after standby.
    localparam int RECOV_W = 4;
    localparam logic [RECOV_W-1:0] RECOVERY_CYCLES = 4'hf;

    // ==========================================================
    // Register byte addresses.
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 12'h008;

    // ==========================================================
    // Field positions and values after reset.
    localparam int CTRL_DISCARD_BIT = 0;
    localparam logic CTRL_DISCARD_RESET = 1'b1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STANDBY_LSB = 2;
    localparam int ST_RECOVER_LSB = 4;
    localparam int ST_VALID_LSB = 6;
    localparam int ST_OVERRUN_LSB = 8;

    // ==========================================================
    // Operating modes set by the two option straps.
    typedef enum logic [1:0] {
        DAS_STANDBY_BOTH,
        DAS_STANDBY_B,
        DAS_NORMAL,
        DAS_ALIGN
    } das_mode_type;

endpackage

// >>> design/das_skid_buffer.sv
// Small shifting buffer whose head entry is always a register.
module das_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Discards every entry.
    input wire logic flush,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    // ==========================================================
    // State.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] word;
        logic [DEPTH-1:0] full;
    } das_buf_state_type;

    das_buf_state_type st;
    das_buf_state_type next_st;
    logic placed;

    // Entry 0 is the head; a pop shifts the rest down one place.
    always_comb begin
        next_st = st;
        placed = 1'b0;
        if (out_ready && st.full[0]) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_st.word[i] = st.word[i + 1];
                next_st.full[i] = st.full[i + 1];
            end
            next_st.full[DEPTH-1] = 1'b0;
        end
        // A push lands in the first free entry left after any pop.
        if (in_valid && in_ready) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!next_st.full[i] && !placed) begin
                    next_st.word[i] = in_data;
                    next_st.full[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
        if (flush) begin
            next_st.full = '0;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Ready is refused only while the last entry is taken.
    assign in_ready = !st.full[DEPTH-1];
    assign out_valid = st.full[0];
    assign out_data = st.word[0];

endmodule // das_skid_buffer

// >>> sim/das_capture_sink.sv
// Downstream capture model that latches one channel's result words.
module das_capture_sink (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Stall request from the bench.
    input wire logic stall,
    // Result stream from the staging block.
    input wire logic valid,
    input wire logic oe_n,
    input wire logic [das_pkg::WORD_W-1:0] bus,
    output logic ready,
    // Captured word, shown for one cycle.
    output logic got,
    output logic [das_pkg::WORD_W-1:0] word
);
    timeunit 1ns;
    timeprecision 1ps;
    import das_pkg::*;
    // The model accepts whenever the bench does not stall it.
    assign ready = !stall;
    // A word is taken only from a driven bus, at a rising edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got <= 1'h0;
            word <= 8'h00;
        end else begin
            got <= valid && ready && !oe_n;
            word <= bus;
        end
    end
endmodule // das_capture_sink

// >>> sim/das_staging_tb_top.sv
// Self-checking bench of the dual converter output staging block.
module das_staging_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import das_pkg::*;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
    // ==========================================================
    // Bench signals.
    logic pclk = 1'h0, presetn = 1'h0, sclk = 1'h0, hold = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, track = 1'h0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, exp_rd;
    logic [WORD_W-1:0] exp_a, exp_b;
    logic pready, pslverr, err, stall = 1'h0;
    logic s1 = 1'h0, s2 = 1'h0, fmt = 1'h0;
    logic [RAW_W-1:0] raw_a = 13'h0, raw_b = 13'h0;
    logic [WORD_W-1:0] bus_a, bus_b, word_a, word_b, qa[$], qb[$];
    logic oe_a, oe_b, val_a, val_b, rdy_a, rdy_b, got_a, got_b;
    logic [2:0] ph [4] = '{3'h4, 3'h7, 3'h2, 3'h0};
    int bad_count = 0, check_count = 0, seed = 32'h4e77, k = 0;
    always #2.5 pclk = ~pclk;
    das_staging dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .option_select_first(s1),
        .option_select_second(s2), .format_select(fmt),
        .chan_a_sample_clock(sclk), .chan_a_raw_code(raw_a),
        .chan_b_sample_clock(sclk), .chan_b_raw_code(raw_b),
        .chan_a_result_bus(bus_a), .chan_a_result_oe_n(oe_a),
        .chan_a_result_valid(val_a), .chan_a_result_ready(rdy_a),
        .chan_b_result_bus(bus_b), .chan_b_result_oe_n(oe_b),
        .chan_b_result_valid(val_b), .chan_b_result_ready(rdy_b));
    das_capture_sink cap_a (.pclk(pclk), .presetn(presetn), .stall(stall),
        .valid(val_a), .oe_n(oe_a), .bus(bus_a), .ready(rdy_a),
        .got(got_a), .word(word_a));
    das_capture_sink cap_b (.pclk(pclk), .presetn(presetn), .stall(stall),
        .valid(val_b), .oe_n(oe_b), .bus(bus_b), .ready(rdy_b),
        .got(got_b), .word(word_b));
    // ==========================================================
    // Helpers.
    // Expected word from five stage codes and the flash code.
    function automatic logic [7:0] exp_word(logic [12:0] r, logic f);
        int s;
        logic [1:0] c;
        s = r[2:0];
        for (int i = 0; i < 5; i++) begin
            c = r[12-2*i -: 2];
            s += int'((c == 2'h3) ? 2'h2 : c) << (6 - i);
        end
        if (s > 255) s = 255;
        exp_word = s[7:0] ^ {f, 7'h00};
    endfunction
    // One APB transfer; read data and error are kept in rd and err.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Resets the block with the given straps and format.
    task automatic do_reset(input logic [2:0] m);
        presetn <= 1'h0;
        {s1, s2, fmt} <= m;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        qa.delete();
        qb.delete();
        k = 0;
        repeat (6) @(posedge pclk);
    endtask
    // Runs n sample clocks of 16 cycles and records expected words.
    task automatic run(input int n);
        repeat (n) begin
            @(posedge pclk);
            sclk <= 1'h1;
            if (track && k >= 15) begin
                if (s1 | s2) qa.push_back(exp_word(raw_a, fmt));
                if (s1) qb.push_back(exp_word(raw_b, fmt));
            end
            k++;
            repeat (8) @(posedge pclk);
            sclk <= 1'h0;
            raw_a <= RAW_W'($random(seed));
            raw_b <= RAW_W'($random(seed));
            repeat (7) @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Far side stalls at random, or steadily while hold is set.
    always @(posedge pclk) stall <= hold | (($random(seed) & 3) == 0);
    // Captured words are compared in order against the expectations.
    always @(posedge pclk) begin
        if (track && got_a === 1'h1) begin
            `CHK(qa.size() != 0, 1'h1)
            if (qa.size() != 0) begin
                exp_a = qa.pop_front();
                `CHK(word_a, exp_a)
            end
        end
        if (track && got_b === 1'h1) begin
            `CHK(qb.size() != 0, 1'h1)
            if (qb.size() != 0) begin
                exp_b = qb.pop_front();
                `CHK(word_b, exp_b)
            end
        end
    end
    // Watchdog that cuts a hang short.
    initial begin
        #50000;
        bad_count++;
        final_report();
    end
    // Main sequence: one phase per strap setting, then an overrun.
    initial begin
        track = 1'h1;
        for (int t = 0; t < 4; t++) begin
            do_reset(ph[t]);
            run(30);
            `CHK(oe_a, !(ph[t][2] | ph[t][1]))
            `CHK(oe_b, !ph[t][2])
            `CHK(qa.size(), (ph[t][2] | ph[t][1]) ? 4 : 0)
            `CHK(qb.size(), ph[t][2] ? 4 : 0)
            apb(1'h0, COUNT_ADDR, 32'h0);
            exp_rd = {ph[t][2] ? 16'h000b : 16'h0000,
                      (ph[t][2] | ph[t][1]) ? 16'h000b : 16'h0000};
            `CHK(rd, exp_rd)
            apb(1'h0, STATUS_ADDR, 32'h0);
            `CHK(rd[1:0], ph[t][2:1])
            $display("test %0d done", t);
        end
        track = 1'h0;
        hold = 1'h1;
        do_reset(3'h4);
        run(30);
        apb(1'h0, STATUS_ADDR, 32'h0);
        `CHK(rd[9:6], 4'hf)
        apb(1'h1, STATUS_ADDR, 32'h300);
        apb(1'h0, STATUS_ADDR, 32'h0);
        `CHK(rd[9:8], 2'h0)
        apb(1'h0, 12'h00c, 32'h0);
        `CHK({err, rd}, {1'h1, 32'h0})
        $display("test 4 done");
        final_report();
    end
endmodule // das_staging_tb_top
